// >>> hw/timer_pkg.sv
package timer_pkg;

  // register offsets on the 3-bit register port
  localparam logic [2:0] OFS_CTRL0 = 3'h0;
  localparam logic [2:0] OFS_CTRL1 = 3'h1;
  localparam logic [2:0] OFS_CNT_LO = 3'h2;
  localparam logic [2:0] OFS_CNT_HI = 3'h3;
  localparam logic [2:0] OFS_CMPA_LO = 3'h4;
  localparam logic [2:0] OFS_CMPA_HI = 3'h5;
  localparam logic [2:0] OFS_CMPP_LO = 3'h6;
  localparam logic [2:0] OFS_CMPP_HI = 3'h7;

  // values after reset
  localparam logic [7:0] RST_CTRL0 = 8'h00;
  localparam logic [7:0] RST_CTRL1 = 8'h00;
  localparam logic [9:0] RST_CNT = 10'h000;
  localparam logic [9:0] RST_CMPA = 10'h000;
  localparam logic [9:0] RST_CMPP = 10'h000;

  // field positions
  localparam int CTRL0_ON_BIT = 3;

  // prescaler terminal counts
  localparam logic [1:0] SYS_DIV4_LAST = 2'h3;
  localparam logic [3:0] HI_DIV16_LAST = 4'hf;
  localparam logic [5:0] HI_DIV64_LAST = 6'h3f;

  typedef enum logic [1:0] {
    MODE_CMP = 2'b00,
    MODE_CAP = 2'b01,
    MODE_PWM = 2'b10,
    MODE_TMR = 2'b11
  } mode_t;

  typedef enum logic [2:0] {
    CK_SYS4 = 3'b000,
    CK_SYS = 3'b001,
    CK_HI16 = 3'b010,
    CK_HI64 = 3'b011,
    CK_TBC = 3'b100,
    CK_HI = 3'b101,
    CK_EXT_R = 3'b110,
    CK_EXT_F = 3'b111
  } clk_sel_t;

  typedef struct packed {
    logic       pause_control;
    clk_sel_t   clock_select;
    logic       counter_on;
    logic [2:0] unused;
  } ctrl0_t;

  typedef struct packed {
    mode_t      mode_select;
    logic [1:0] output_function;
    logic       output_level_control;
    logic       output_invert;
    logic       capture_source_select;
    logic       clear_select;
  } ctrl1_t;

  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_t;

endpackage : timer_pkg

// >>> hw/periodic_timer_10bit.sv
`timescale 1ns/10ps
// Contract
// [R1] 10-bit up-counter advances on selected clock tick
// [R2] clock select picks one of eight sources
// [R3] pause holds counter, resume from held value
// [R4] counter-on rise clears; off keeps residual value
// [R5] software cannot load the counter
// [R6] overflow or selected match clears, raises flag
// [R7] counter-on rise restores initial output level
// [R8] mode select picks mode; timer mode pin unused
// [R9] software switches timer off before mode change
// [R10] compare A match drives pin per function
// [R11] requested level equal initial gives no change
// [R12] pwm function: inactive, active, pwm, single
// [R13] software changes pwm function only when off
// [R14] capture edge select: rise, fall, both, off
// [R15] capture source: capture pin or clock pin
// [R16] level bit: initial level or pwm active
// [R17] invert bit flips pin except timer mode; the pin is also held low in capture mode
// [R18] clear select: A match or P match/overflow
// [R19] clear select ignored in pwm, pulse, capture
// [R20] counter readable as low byte, high bits
// [R21] compare A held as read/write byte pair
// [R22] two comparators check counter continuously
// [R23] compare A zero: overflow at 3ff, no flag
// [R24] duty at or above period gives full duty
// [R25] clear select zero raises both match flags
// [R26] pin edges synchronised before use
module periodic_timer_10bit (
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire timer_pkg::reg_req_t reg_req,
  output logic [7:0]             reg_rdata,
  input  wire logic              high_clock_tick,
  input  wire logic              timebase_clock_tick,
  input  wire logic              ext_clock_pin,
  input  wire logic              capture_input_pin,
  output logic                   timer_out,
  output logic                   timer_out_en,
  output logic                   compare_a_flag,
  output logic                   compare_p_flag
);
  import timer_pkg::*;

  function automatic logic hits(input logic [9:0] nxt,
                                input logic [9:0] cmp);
    hits = (nxt == cmp);
  endfunction : hits

  ctrl0_t     ctrl0_ff;
  ctrl1_t     ctrl1_ff;
  logic [9:0] cnt_ff;
  logic [9:0] cmpa_ff;
  logic [9:0] cmpp_ff;
  logic       on_d_ff;
  logic [1:0] div4_ff;
  logic [5:0] hdiv_ff;
  logic [1:0] ext_sync_ff;
  logic [1:0] cap_sync_ff;
  logic       ext_d_ff;
  logic       cap_d_ff;
  logic       state_ff;
  logic [7:0] rdata_ff;
  logic       out_ff;
  logic       out_en_ff;
  logic       aflag_ff;
  logic       pflag_ff;

  logic       wr_ctrl0;
  logic       wr_ctrl1;
  logic       ext_rise;
  logic       ext_fall;
  logic       cap_src;
  logic       cap_prev;
  logic       cap_rise;
  logic       cap_fall;
  logic       tick;
  logic       run;
  logic       on_rise;
  logic [9:0] cnt_plus;
  logic       a_hit;
  logic       p_hit;
  logic       cmp_like;
  logic       single;
  logic       pwm;
  logic       clr_hit;
  logic       a_flag_ev;
  logic       p_flag_ev;
  logic       cap_ev;
  logic       sp_trig;
  logic       sp_stop;
  logic       req_lvl;
  logic       cmp_act;
  logic       pwm_act;
  logic       act;
  logic       nxt_state;
  logic       nxt_on;
  logic [9:0] nxt_cnt;
  logic [7:0] nxt_rdata;
  logic       nxt_out;
  logic       nxt_out_en;

  assign wr_ctrl0 = reg_req.wr && reg_req.addr == OFS_CTRL0;
  assign wr_ctrl1 = reg_req.wr && reg_req.addr == OFS_CTRL1;

  // pin edges seen only after the second sync stage
  assign ext_rise = ext_sync_ff[1] && !ext_d_ff; // R26
  assign ext_fall = !ext_sync_ff[1] && ext_d_ff; // R26
  assign cap_src = ctrl1_ff.capture_source_select ? ext_sync_ff[1] // R15
                                                  : cap_sync_ff[1];
  assign cap_prev = ctrl1_ff.capture_source_select ? ext_d_ff : cap_d_ff;
  assign cap_rise = cap_src && !cap_prev;
  assign cap_fall = !cap_src && cap_prev;

  // counter clock source
  always_comb
  begin
    unique case (ctrl0_ff.clock_select) // R2
      CK_SYS4: tick = (div4_ff == SYS_DIV4_LAST);
      CK_SYS: tick = 1'b1;
      CK_HI16: tick = high_clock_tick && hdiv_ff[3:0] == HI_DIV16_LAST;
      CK_HI64: tick = high_clock_tick && hdiv_ff == HI_DIV64_LAST;
      CK_TBC: tick = timebase_clock_tick;
      CK_HI: tick = high_clock_tick;
      CK_EXT_R: tick = ext_rise;
      CK_EXT_F: tick = ext_fall;
    endcase
  end

  assign on_rise = ctrl0_ff.counter_on && !on_d_ff; // R4
  assign run = ctrl0_ff.counter_on && !ctrl0_ff.pause_control && tick; // R3
  assign cnt_plus = 10'(cnt_ff + 10'h001);

  // match means the counter is about to reach the compare value
  // no match in the clearing cycle, the counter restarts from zero there
  assign a_hit = run && !on_rise && hits(cnt_plus, cmpa_ff); // R22
  assign p_hit = run && !on_rise && hits(cnt_plus, cmpp_ff); // R22

  assign cmp_like = ctrl1_ff.mode_select == MODE_CMP
                 || ctrl1_ff.mode_select == MODE_TMR;
  assign pwm = ctrl1_ff.mode_select == MODE_PWM;
  assign single = pwm && ctrl1_ff.output_function == 2'b11;

  // clear select only steers the compare and timer modes
  assign clr_hit = cmp_like ? (ctrl1_ff.clear_select ? a_hit : p_hit) // R18
                            : (!single && p_hit); // R19

  assign cap_ev = ctrl1_ff.mode_select == MODE_CAP && ctrl0_ff.counter_on
               && ((ctrl1_ff.output_function == 2'b00 && cap_rise)
                || (ctrl1_ff.output_function == 2'b01 && cap_fall)
                || (ctrl1_ff.output_function == 2'b10
                    && (cap_rise || cap_fall))); // R14

  // a zero compare A is the overflow and raises no flag
  assign a_flag_ev = (ctrl1_ff.mode_select == MODE_CAP) ? cap_ev
                   : (a_hit && cmpa_ff != RST_CMPA); // R6 R23
  assign p_flag_ev = p_hit && !single
                  && !(cmp_like && ctrl1_ff.clear_select); // R25

  // single pulse: clock pin starts it, compare A ends it
  assign sp_trig = single && ext_rise;
  assign sp_stop = single && a_hit;
  assign nxt_on = sp_trig ? 1'b1
                : sp_stop ? 1'b0
                : wr_ctrl0 ? reg_req.wdata[CTRL0_ON_BIT]
                : ctrl0_ff.counter_on;

  // only clears reach the counter from software
  assign nxt_cnt = (on_rise || clr_hit) ? RST_CNT // R5 R6
                 : run ? cnt_plus : cnt_ff; // R1

  // compare mode pin state before inversion
  assign req_lvl = ctrl1_ff.output_function == 2'b11 ? !state_ff
                 : ctrl1_ff.output_function[1];
  assign cmp_act = ctrl1_ff.output_function != 2'b00
                && req_lvl != ctrl1_ff.output_level_control; // R11
  assign nxt_state = on_rise ? ctrl1_ff.output_level_control // R7
                   : (ctrl1_ff.mode_select == MODE_CMP && a_flag_ev
                      && cmp_act) ? req_lvl : state_ff; // R10

  always_comb
  begin
    unique case (ctrl1_ff.output_function) // R12
      2'b00: pwm_act = 1'b0;
      2'b01: pwm_act = 1'b1;
      2'b10: pwm_act = ctrl0_ff.counter_on && !on_rise
                    && ((cmpp_ff != RST_CMPP && cmpa_ff >= cmpp_ff) // R24
                     || cnt_ff < cmpa_ff);
      2'b11: pwm_act = ctrl0_ff.counter_on && !on_rise; // R7
    endcase
  end

  assign act = pwm ? (pwm_act ? ctrl1_ff.output_level_control // R16
                              : !ctrl1_ff.output_level_control)
                   : state_ff;
  assign nxt_out_en = ctrl1_ff.mode_select == MODE_CMP || pwm; // R8
  assign nxt_out = nxt_out_en && (act ^ ctrl1_ff.output_invert); // R17

  always_comb
  begin
    unique case (reg_req.addr)
      OFS_CTRL0: nxt_rdata = {ctrl0_ff[7:3], 3'h0};
      OFS_CTRL1: nxt_rdata = ctrl1_ff;
      OFS_CNT_LO: nxt_rdata = cnt_ff[7:0]; // R20
      OFS_CNT_HI: nxt_rdata = {6'h00, cnt_ff[9:8]}; // R20
      OFS_CMPA_LO: nxt_rdata = cmpa_ff[7:0]; // R21
      OFS_CMPA_HI: nxt_rdata = {6'h00, cmpa_ff[9:8]}; // R21
      OFS_CMPP_LO: nxt_rdata = cmpp_ff[7:0];
      OFS_CMPP_HI: nxt_rdata = {6'h00, cmpp_ff[9:8]};
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      ctrl0_ff <= ctrl0_t'(RST_CTRL0);
      ctrl1_ff <= ctrl1_t'(RST_CTRL1);
      on_d_ff <= 1'b0;
      cnt_ff <= RST_CNT;
      state_ff <= 1'b0;
    end
    else
    begin
      if (wr_ctrl0)
        ctrl0_ff[7:4] <= reg_req.wdata[7:4];
      ctrl0_ff.counter_on <= nxt_on;
      if (wr_ctrl1)
        ctrl1_ff <= ctrl1_t'(reg_req.wdata);
      on_d_ff <= ctrl0_ff.counter_on;
      cnt_ff <= nxt_cnt;
      state_ff <= nxt_state;
    end
  end

  // compare registers; a capture wins over a software write
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      cmpa_ff <= RST_CMPA;
      cmpp_ff <= RST_CMPP;
    end
    else
    begin
      if (cap_ev)
        cmpa_ff <= cnt_ff; // R14
      else if (reg_req.wr && reg_req.addr == OFS_CMPA_LO)
        cmpa_ff[7:0] <= reg_req.wdata; // R21
      else if (reg_req.wr && reg_req.addr == OFS_CMPA_HI)
        cmpa_ff[9:8] <= reg_req.wdata[1:0]; // R21
      if (reg_req.wr && reg_req.addr == OFS_CMPP_LO)
        cmpp_ff[7:0] <= reg_req.wdata;
      if (reg_req.wr && reg_req.addr == OFS_CMPP_HI)
        cmpp_ff[9:8] <= reg_req.wdata[1:0];
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      div4_ff <= 2'h0;
      hdiv_ff <= 6'h00;
      ext_sync_ff <= 2'h0;
      cap_sync_ff <= 2'h0;
      ext_d_ff <= 1'b0;
      cap_d_ff <= 1'b0;
    end
    else
    begin
      div4_ff <= 2'(div4_ff + 2'h1);
      if (high_clock_tick)
        hdiv_ff <= 6'(hdiv_ff + 6'h01);
      ext_sync_ff <= {ext_sync_ff[0], ext_clock_pin}; // R26
      cap_sync_ff <= {cap_sync_ff[0], capture_input_pin}; // R26
      ext_d_ff <= ext_sync_ff[1];
      cap_d_ff <= cap_sync_ff[1];
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      rdata_ff <= 8'h00;
      out_ff <= 1'b0;
      out_en_ff <= 1'b0;
      aflag_ff <= 1'b0;
      pflag_ff <= 1'b0;
    end
    else
    begin
      rdata_ff <= reg_req.rd ? nxt_rdata : 8'h00;
      out_ff <= nxt_out;
      out_en_ff <= nxt_out_en;
      aflag_ff <= a_flag_ev; // R6
      pflag_ff <= p_flag_ev; // R6
    end
  end

  assign reg_rdata = rdata_ff;
  assign timer_out = out_ff;
  assign timer_out_en = out_en_ff;
  assign compare_a_flag = aflag_ff;
  assign compare_p_flag = pflag_ff;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  a_on_rise_clear: // R4
    assert property (on_rise |=> cnt_ff == 10'h000)
    else $error("counter not cleared by counter-on rise");

  a_off_hold_value: // R4
    assert property (!ctrl0_ff.counter_on |=> $stable(cnt_ff))
    else $error("counter moved while off");

  a_pause_hold: // R3
    assert property (ctrl0_ff.pause_control && !on_rise
                     |=> cnt_ff == $past(cnt_ff))
    else $error("counter moved while paused");

  a_count_step: // R1
    assert property (run && !clr_hit && !on_rise
                     |=> cnt_ff == 10'($past(cnt_ff) + 10'h001))
    else $error("counter did not advance by one");

  a_sys_tick_run: // R2
    assert property (ctrl0_ff.clock_select == CK_SYS
                     && ctrl0_ff.counter_on && !ctrl0_ff.pause_control
                     |-> run)
    else $error("system clock source did not tick");

  a_clear_by_a: // R18
    assert property (cmp_like && ctrl1_ff.clear_select && a_hit
                     |=> cnt_ff == 10'h000)
    else $error("compare A match did not clear counter");

  a_pflag_both: // R25
    assert property (cmp_like && !ctrl1_ff.clear_select && p_hit
                     |=> compare_p_flag ##1 !compare_p_flag)
    else $error("compare P flag not a single pulse");

  a_zero_a_noflag: // R23
    assert property (ctrl1_ff.mode_select == MODE_CMP
                     && cmpa_ff == 10'h000 |=> !compare_a_flag)
    else $error("flag raised with compare A zero");

  a_capture_store: // R14
    assert property (cap_ev |=> cmpa_ff == $past(cnt_ff)
                     && compare_a_flag)
    else $error("capture did not store counter");

  a_timer_pin_off: // R8
    assert property (ctrl1_ff.mode_select == MODE_TMR
                     |=> !timer_out_en && !timer_out)
    else $error("pin driven in timer mode");

  a_pwm_full_duty: // R24
    assert property (pwm && ctrl1_ff.output_function == 2'b10
                     && ctrl0_ff.counter_on && !on_rise
                     && cmpp_ff != 10'h000 && cmpa_ff >= cmpp_ff
                     |=> timer_out == $past(ctrl1_ff.output_level_control
                                            ^ ctrl1_ff.output_invert))
    else $error("pwm not at full duty");

  a_read_counter: // R20
    assert property (reg_req.rd && reg_req.addr == OFS_CNT_HI
                     |=> reg_rdata == {6'h00, $past(cnt_ff[9:8])})
    else $error("counter high read wrong");

endmodule : periodic_timer_10bit

// >>> verif/pin_source_model.sv
`timescale 1ns/10ps
module pin_source_model (
  input  wire logic clk,
  output logic      ext_clock_pin,
  output logic      capture_input_pin,
  input  wire logic compare_a_flag,
  input  wire logic compare_p_flag
);
  int a_count = 0;
  int p_count = 0;

  initial
  begin
    ext_clock_pin = 1'b0;
    capture_input_pin = 1'b0;
  end

  // counts one-cycle flag pulses
  always @(posedge clk)
  begin
    if (compare_a_flag === 1'b1)
      a_count <= a_count + 1;
    if (compare_p_flag === 1'b1)
      p_count <= p_count + 1;
  end

  // slow pulses so each level outlasts the synchroniser
  task automatic ext_pulses(input int n);
    repeat (n)
    begin
      repeat (4) @(posedge clk);
      ext_clock_pin <= !ext_clock_pin;
      repeat (4) @(posedge clk);
      ext_clock_pin <= !ext_clock_pin;
    end
    repeat (6) @(posedge clk);
  endtask : ext_pulses

  task automatic cap_level(input logic v);
    @(posedge clk);
    capture_input_pin <= v;
    repeat (6) @(posedge clk);
  endtask : cap_level
endmodule : pin_source_model

// >>> verif/tb_periodic_timer_10bit.sv
`timescale 1ns/10ps
`define CHK(n, e, a) \
  begin \
    checks++; \
    if ((a) !== (e)) \
    begin \
      fail_count++; \
      $display("unexpected %s exp %h got %h", n, e, a); \
    end \
  end
module tb_periodic_timer_10bit;
  import timer_pkg::*;
  logic       clk;
  logic       sys_rst;
  reg_req_t   req;
  logic [7:0] rdata;
  logic       hi_tick;
  logic       tb_tick;
  logic       ext_pin;
  logic       cap_pin;
  logic       t_out;
  logic       t_en;
  logic       fl_a;
  logic       fl_p;
  int         fail_count = 0;
  int         checks = 0;
  int         cycles = 0;
  int         hi_cnt = 0;
  int         nh;
  int         na;
  int         np;
  logic [7:0] d;
  logic [9:0] v;
  logic [1:0] f;
  logic       lvl;
  logic       inv;
  logic       eo;
  int         rate[6] = '{128, 512, 16, 4, 128, 256};
  logic [9:0] cap_a[4] = '{10'h002, 10'h003, 10'h003, 10'h155};
  int         cap_n[4] = '{1, 1, 2, 0};

  periodic_timer_10bit dut_u (.clk(clk), .sys_rst(sys_rst),
    .reg_req(req), .reg_rdata(rdata), .high_clock_tick(hi_tick),
    .timebase_clock_tick(tb_tick), .ext_clock_pin(ext_pin),
    .capture_input_pin(cap_pin), .timer_out(t_out),
    .timer_out_en(t_en), .compare_a_flag(fl_a), .compare_p_flag(fl_p));

  pin_source_model pin_u (.clk(clk), .ext_clock_pin(ext_pin),
    .capture_input_pin(cap_pin), .compare_a_flag(fl_a),
    .compare_p_flag(fl_p));

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    hi_tick <= cycles[0];
    tb_tick <= (cycles[1:0] == 2'h0);
    if (t_out === 1'b1)
      hi_cnt <= hi_cnt + 1;
    if (cycles == 60000)
    begin
      fail_count++;
      give_verdict();
    end
  end

  task automatic wr(input logic [2:0] a, input logic [7:0] x);
    @(posedge clk);
    req <= '{addr: a, wdata: x, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req <= '0;
  endtask : wr

  task automatic rd(input logic [2:0] a, output logic [7:0] x);
    @(posedge clk);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req <= '0;
    #1;
    x = rdata;
  endtask : rd

  task automatic rd10(input logic [2:0] a, output logic [9:0] x);
    logic [7:0] lo;
    logic [7:0] hi;
    rd(a, lo);
    rd(a + 3'h1, hi);
    `CHK("upper bits", 6'h00, hi[7:2])
    x = {hi[1:0], lo};
  endtask : rd10

  task automatic cfg(input logic [7:0] c1, input logic [9:0] a,
                     input logic [9:0] p);
    wr(OFS_CTRL0, 8'h00);
    wr(OFS_CTRL1, c1);
    wr(OFS_CMPA_LO, a[7:0]);
    wr(OFS_CMPA_HI, {6'h00, a[9:8]});
    wr(OFS_CMPP_LO, p[7:0]);
    wr(OFS_CMPP_HI, {6'h00, p[9:8]});
  endtask : cfg

  task automatic end_test(input string s);
    $display("test %s done", s);
  endtask : end_test

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict

  initial
  begin
    sys_rst = 1'b1;
    req = '0;
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 8; i++)
    begin
      rd(3'(i), d);
      `CHK("reset value", 8'h00, d)
    end
    wr(OFS_CTRL1, 8'h5a);
    rd(OFS_CTRL1, d);
    `CHK("ctrl1", 8'h5a, d)
    wr(OFS_CNT_LO, 8'h55);
    rd(OFS_CNT_LO, d);
    `CHK("counter write", 8'h00, d)
    cfg(8'hc0, 10'h3ff, 10'h000);
    rd10(OFS_CMPA_LO, v);
    `CHK("compare a", 10'h3ff, v)
    end_test("registers");
    wr(OFS_CTRL0, 8'h68);
    pin_u.ext_pulses(5);
    rd10(OFS_CNT_LO, v);
    `CHK("rise count", 10'h005, v)
    wr(OFS_CTRL0, 8'h78);
    pin_u.ext_pulses(3);
    rd10(OFS_CNT_LO, v);
    `CHK("fall count", 10'h008, v)
    wr(OFS_CTRL0, 8'hf8);
    pin_u.ext_pulses(4);
    rd10(OFS_CNT_LO, v);
    `CHK("paused", 10'h008, v)
    wr(OFS_CTRL0, 8'h78);
    pin_u.ext_pulses(2);
    rd10(OFS_CNT_LO, v);
    `CHK("resumed", 10'h00a, v)
    wr(OFS_CTRL0, 8'h70);
    pin_u.ext_pulses(2);
    rd10(OFS_CNT_LO, v);
    `CHK("off residual", 10'h00a, v)
    wr(OFS_CTRL0, 8'h78);
    rd10(OFS_CNT_LO, v);
    `CHK("on clears", 10'h000, v)
    `CHK("timer mode pin", 1'b0, t_en)
    for (int s = 0; s < 6; s++)
    begin
      wr(OFS_CTRL0, 8'h00);
      wr(OFS_CTRL0, {1'b0, 3'(s), 1'b1, 3'h0});
      repeat (510) @(posedge clk);
      wr(OFS_CTRL0, {1'b1, 3'(s), 1'b1, 3'h0});
      rd10(OFS_CNT_LO, v);
      `CHK("rate", 1'b1, (v + 3 >= rate[s]) && (v <= rate[s] + 3))
    end
    end_test("counting");
    for (int k = 0; k < 16; k++)
    begin
      {f, lvl, inv} = 4'(k);
      cfg({2'b00, f, lvl, inv, 2'b01}, 10'h003, 10'h000);
      na = pin_u.a_count;
      np = pin_u.p_count;
      wr(OFS_CTRL0, 8'h68);
      repeat (3) @(posedge clk);
      #1;
      `CHK("initial level", lvl ^ inv, t_out)
      `CHK("pin enable", 1'b1, t_en)
      pin_u.ext_pulses(3);
      eo = (f == 2'h0) ? lvl : (f == 2'h1) ? 1'b0 : (f == 2'h2) ? 1'b1 : !lvl;
      `CHK("match level", eo ^ inv, t_out)
      `CHK("a flags", na + 1, pin_u.a_count)
      `CHK("p flags", np, pin_u.p_count)
      rd10(OFS_CNT_LO, v);
      `CHK("a clear", 10'h000, v)
    end
    cfg(8'h20, 10'h003, 10'h005);
    na = pin_u.a_count;
    np = pin_u.p_count;
    wr(OFS_CTRL0, 8'h68);
    pin_u.ext_pulses(7);
    rd10(OFS_CNT_LO, v);
    `CHK("p clear", 10'h002, v)
    `CHK("both flags", na + np + 2, pin_u.a_count + pin_u.p_count)
    cfg(8'h21, 10'h000, 10'h000);
    na = pin_u.a_count;
    wr(OFS_CTRL0, 8'h18);
    repeat (1100) @(posedge clk);
    `CHK("a zero flags", na, pin_u.a_count)
    end_test("compare");
    for (int k = 0; k < 6; k++)
    begin
      f = 2'(k / 2);
      inv = k[0];
      cfg({2'b10, f, 1'b1, inv, 2'b01}, 10'h005, 10'h004);
      wr(OFS_CTRL0, 8'h18);
      repeat (3) @(posedge clk);
      repeat (16)
      begin
        @(posedge clk);
        #1;
        `CHK("pwm level", (f != 2'h0) ^ inv, t_out)
      end
    end
    cfg(8'ha8, 10'h002, 10'h004);
    wr(OFS_CTRL0, 8'h18);
    repeat (8) @(posedge clk);
    na = pin_u.a_count;
    np = pin_u.p_count;
    nh = hi_cnt;
    repeat (16) @(posedge clk);
    `CHK("pwm duty", nh + 8, hi_cnt)
    `CHK("pwm a flags", na + 4, pin_u.a_count)
    `CHK("pwm p flags", np + 4, pin_u.p_count)
    end_test("pwm");
    cfg(8'hb8, 10'h003, 10'h000);
    wr(OFS_CTRL0, 8'h10);
    na = pin_u.a_count;
    nh = hi_cnt;
    pin_u.ext_pulses(1);
    `CHK("pulse width", nh + 3, hi_cnt)
    `CHK("pulse a flag", na + 1, pin_u.a_count)
    rd(OFS_CTRL0, d);
    `CHK("pulse stops", 8'h10, d)
    `CHK("pulse idle", 1'b0, t_out)
    end_test("pulse");
    for (int k = 0; k < 5; k++)
    begin
      f = (k == 4) ? 2'h1 : 2'(k);
      cfg({2'b01, f, 2'b00, k == 4, 1'b0}, 10'h155, 10'h000);
      na = pin_u.a_count;
      wr(OFS_CTRL0, 8'h68);
      pin_u.ext_pulses((k == 4) ? 3 : 2);
      pin_u.cap_level(1'b1);
      pin_u.ext_pulses((k == 4) ? 0 : 1);
      pin_u.cap_level(1'b0);
      rd10(OFS_CMPA_LO, v);
      `CHK("captured", (k == 4) ? 10'h003 : cap_a[k], v)
      `CHK("captures", na + ((k == 4) ? 3 : cap_n[k]), pin_u.a_count)
      `CHK("capture pin", 1'b0, t_en)
    end
    end_test("capture");
    give_verdict();
  end
endmodule : tb_periodic_timer_10bit
